// ---- laser_seq_pkg.sv ----
// constants shared by the laser enable sequencer and its countdown timer
package laser_seq_pkg;
    // clock and timing
    localparam int unsigned CLK_FREQ_KHZ     = 100000;
    localparam int unsigned INHIBIT_TIME_MS  = 5000;
    localparam int unsigned INHIBIT_CYCLES   = INHIBIT_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned TIMER_W          = 29;
    localparam int unsigned PWM_CNT_W        = 16;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS          = 8'h00;
    localparam logic [7:0] STATUS_OFS        = 8'h04;
    localparam logic [7:0] INT_STAT_OFS      = 8'h08;
    localparam logic [7:0] INT_MASK_OFS      = 8'h0C;
    localparam logic [7:0] PWM_HIGH_OFS      = 8'h10;
    localparam logic [7:0] PWM_PERIOD_OFS    = 8'h14;

    // control register
    localparam int unsigned CTRL_EMIT_EN_BIT = 0;
    localparam logic [0:0]  CTRL_RESET       = 1'h1;

    // status register fields
    localparam int unsigned ST_READY_BIT     = 0;
    localparam int unsigned ST_READY_DONE_BIT = 1;
    localparam int unsigned ST_SHUTTER_BIT   = 2;
    localparam int unsigned ST_SHUT_DONE_BIT = 3;
    localparam int unsigned ST_INTERLOCK_BIT = 4;
    localparam int unsigned ST_ARMED_BIT     = 5;
    localparam int unsigned ST_ACTIVE_BIT    = 6;
    localparam int unsigned ST_RF_POWER_BIT  = 7;
    localparam int unsigned ST_VARIANT_BIT   = 8;
    localparam int unsigned ST_W             = 9;

    // interrupt events, same layout in status and mask
    localparam int unsigned EV_READY_UP      = 0;
    localparam int unsigned EV_READY_DOWN    = 1;
    localparam int unsigned EV_ILOCK_LOSS    = 2;
    localparam int unsigned EV_EMIT_START    = 3;
    localparam int unsigned EV_W             = 4;
    localparam logic [3:0]  INT_MASK_RESET   = 4'h0;
endpackage

// ---- inhibit_timer.sv ----
// restartable countdown that reports when an inhibit interval has run out
`timescale 1ns/1ps
`default_nettype none
module inhibit_timer #(
    parameter int unsigned CNT_W  = laser_seq_pkg::TIMER_W,
    parameter int unsigned CYCLES = laser_seq_pkg::INHIBIT_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    input  wire logic run,
    output logic      done_q
);
    logic [CNT_W-1:0] cnt_q;

    // restart reloads; dropping run also reloads so a later run starts a full interval
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (restart || !run)
            cnt_q <= CNT_W'(CYCLES - 1);
        else if (cnt_q != '0)
            cnt_q <= cnt_q - CNT_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_q <= 1'b0;
        else
            done_q <= run && !restart && (cnt_q == '0);
    end
endmodule
`default_nettype wire

// ---- laser_enable_sequencer.sv ----
// laser enable sequencer: arming, interlock latch, inhibit countdowns, rf gating, apb regs
//
// Behaviour
// - start request held keeps laser disabled, rf unpowered
// - request release lights ready, starts five-second countdown
// - keyswitch off makes start request ignored
// - interlock inactive removes rf power
// - keyswitch units latch interlock loss until toggle
// - unlatched variant restores ready when interlock returns
// - shutter request and shutter switch both required
// - pwm ignored five seconds after shutter request
// - output power follows command duty cycle
// - ready output with five-second inhibit after closing
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module laser_enable_sequencer #(
    parameter int unsigned INHIBIT_CYCLES = laser_seq_pkg::INHIBIT_CYCLES,
    parameter int unsigned PWM_W          = laser_seq_pkg::PWM_CNT_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        start_req,
    input  wire logic        interlock_in,
    input  wire logic        shutter_req,
    input  wire logic        shutter_switch_open,
    input  wire logic        keyswitch_on,
    input  wire logic        unlatched_variant,
    input  wire logic        pwm_cmd,
    output logic             rf_power_en,
    output logic             rf_drive,
    output logic             ready_out,
    output logic             laser_active,
    output logic             shutter_open_out,
    output logic             interlock_open_out,
    output logic             irq
);
    logic                              emit_en_q;
    logic [laser_seq_pkg::EV_W-1:0]    int_stat_q;
    logic [laser_seq_pkg::EV_W-1:0]    int_mask_q;
    logic [laser_seq_pkg::EV_W-1:0]    events;
    logic                              req_eff;
    logic                              req_eff_prev_q;
    logic                              key_prev_q;
    logic                              ilock_prev_q;
    logic                              armed_q;
    logic                              arm_event;
    logic                              ready_d;
    logic                              ready_q;
    logic                              ready_done;
    logic                              shutter_ok;
    logic                              shutter_prev_q;
    logic                              shutter_done;
    logic                              drive_d;
    logic                              power_d;
    logic                              pwm_prev_q;
    logic [PWM_W-1:0]                  hi_cnt_q;
    logic [PWM_W-1:0]                  per_cnt_q;
    logic [PWM_W-1:0]                  pwm_high_q;
    logic [PWM_W-1:0]                  pwm_period_q;
    logic                              acc_done;
    logic                              rd_done;
    logic                              wr_done;
    logic                              addr_ok;
    logic [31:0]                       rdata_d;
    logic [laser_seq_pkg::ST_W-1:0]    status_w;

    function automatic logic [PWM_W-1:0] sat_inc(input logic [PWM_W-1:0] v);
        return (v == {PWM_W{1'b1}}) ? v : v + PWM_W'(1);
    endfunction

    // request counts only while keyswitch on, except on units without keyswitch
    assign req_eff = start_req && (unlatched_variant || keyswitch_on);

    // arming follows a release of the request or the keyswitch coming on
    assign arm_event = (req_eff_prev_q && !req_eff)
                     || (keyswitch_on && !key_prev_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_eff_prev_q <= 1'b0;
            key_prev_q     <= 1'b1; // a key already on at power-up must not arm
            ilock_prev_q   <= 1'b0;
            shutter_prev_q <= 1'b0;
            pwm_prev_q     <= 1'b0;
        end
        else
        begin
            req_eff_prev_q <= req_eff;
            key_prev_q     <= keyswitch_on;
            ilock_prev_q   <= interlock_in;
            shutter_prev_q <= shutter_ok;
            pwm_prev_q     <= pwm_cmd;
        end
    end

    // latched arming on keyswitch units; a lost interlock stays lost until re-armed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_q <= 1'b0;
        else if (!interlock_in || !keyswitch_on || req_eff)
            armed_q <= 1'b0;
        else if (arm_event)
            armed_q <= 1'b1;
    end

    // the unlatched variant needs no arming, only interlock and no request
    assign ready_d = !req_eff && interlock_in
                   && (unlatched_variant || armed_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ready_q <= 1'b0;
        else
            ready_q <= ready_d;
    end

    // countdown from ready first closing; interlock return restarts it through ready, on keyswitch units only after re-arming
    inhibit_timer #(
        .CNT_W  (laser_seq_pkg::TIMER_W),
        .CYCLES (INHIBIT_CYCLES)
    ) u_ready_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (ready_d && !ready_q),
        .run     (ready_d),
        .done_q  (ready_done)
    );

    assign shutter_ok = shutter_req && shutter_switch_open;

    inhibit_timer #(
        .CNT_W  (laser_seq_pkg::TIMER_W),
        .CYCLES (INHIBIT_CYCLES)
    ) u_shutter_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (shutter_ok && !shutter_prev_q),
        .run     (shutter_ok),
        .done_q  (shutter_done)
    );

    // rf supply is cut outright by a held request or missing interlock
    assign power_d = ready_d && shutter_ok;

    // pwm passes one-for-one so average rf power tracks duty cycle
    assign drive_d = pwm_cmd && power_d && ready_q && ready_done
                   && shutter_done && emit_en_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rf_power_en        <= 1'b0;
            rf_drive           <= 1'b0;
            ready_out          <= 1'b0;
            shutter_open_out   <= 1'b0;
            interlock_open_out <= 1'b0;
        end
        else
        begin
            rf_power_en        <= power_d;
            rf_drive           <= drive_d;
            ready_out          <= ready_d;
            shutter_open_out   <= shutter_ok;
            interlock_open_out <= !interlock_in;
        end
    end

    // active means a beam has been gated and the pwm period count has not saturated since
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            laser_active <= 1'b0;
        else if (!power_d || !ready_done || !shutter_done || !emit_en_q)
            laser_active <= 1'b0;
        else if (drive_d)
            laser_active <= 1'b1;
        else if (per_cnt_q == {PWM_W{1'b1}})
            laser_active <= 1'b0;
    end

    // duty measurement captured at each rising edge; counters saturate so an overlong high time or period reads as full scale
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hi_cnt_q     <= '0;
            per_cnt_q    <= '0;
            pwm_high_q   <= '0;
            pwm_period_q <= '0;
        end
        else if (pwm_cmd && !pwm_prev_q)
        begin
            pwm_high_q   <= hi_cnt_q;
            pwm_period_q <= per_cnt_q;
            hi_cnt_q     <= PWM_W'(1);
            per_cnt_q    <= PWM_W'(1);
        end
        else
        begin
            per_cnt_q <= sat_inc(per_cnt_q);
            if (pwm_cmd)
                hi_cnt_q <= sat_inc(hi_cnt_q);
        end
    end

    assign events[laser_seq_pkg::EV_READY_UP]   = ready_d && !ready_q;
    assign events[laser_seq_pkg::EV_READY_DOWN] = !ready_d && ready_q;
    assign events[laser_seq_pkg::EV_ILOCK_LOSS] = ilock_prev_q && !interlock_in;
    assign events[laser_seq_pkg::EV_EMIT_START] = drive_d && !laser_active;

    // apb: one wait state, pready high in the second access cycle
    assign acc_done = psel && penable && pready;
    assign rd_done  = acc_done && !pwrite;
    assign wr_done  = acc_done && pwrite && !pslverr;

    always_comb
    begin
        status_w = '0;
        status_w[laser_seq_pkg::ST_READY_BIT]      = ready_q;
        status_w[laser_seq_pkg::ST_READY_DONE_BIT] = ready_done;
        status_w[laser_seq_pkg::ST_SHUTTER_BIT]    = shutter_ok;
        status_w[laser_seq_pkg::ST_SHUT_DONE_BIT]  = shutter_done;
        status_w[laser_seq_pkg::ST_INTERLOCK_BIT]  = interlock_in;
        status_w[laser_seq_pkg::ST_ARMED_BIT]      = armed_q;
        status_w[laser_seq_pkg::ST_ACTIVE_BIT]     = laser_active;
        status_w[laser_seq_pkg::ST_RF_POWER_BIT]   = rf_power_en;
        status_w[laser_seq_pkg::ST_VARIANT_BIT]    = unlatched_variant;
    end

    always_comb
    begin
        addr_ok = 1'b1;
        rdata_d = '0;
        unique case (paddr)
            laser_seq_pkg::CTRL_OFS:       rdata_d = 32'(emit_en_q);
            laser_seq_pkg::STATUS_OFS:     rdata_d = 32'(status_w);
            laser_seq_pkg::INT_STAT_OFS:   rdata_d = 32'(int_stat_q);
            laser_seq_pkg::INT_MASK_OFS:   rdata_d = 32'(int_mask_q);
            laser_seq_pkg::PWM_HIGH_OFS:   rdata_d = 32'(pwm_high_q);
            laser_seq_pkg::PWM_PERIOD_OFS: rdata_d = 32'(pwm_period_q);
            default:                       addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (psel && penable && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= !addr_ok;
            prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            emit_en_q  <= laser_seq_pkg::CTRL_RESET;
            int_mask_q <= laser_seq_pkg::INT_MASK_RESET;
        end
        else if (wr_done && paddr == laser_seq_pkg::CTRL_OFS)
            emit_en_q  <= pwdata[laser_seq_pkg::CTRL_EMIT_EN_BIT];
        else if (wr_done && paddr == laser_seq_pkg::INT_MASK_OFS)
            int_mask_q <= pwdata[laser_seq_pkg::EV_W-1:0];
    end

    // read clears only the bits it returned, so an event after data capture survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat_q <= '0;
        else if (rd_done && paddr == laser_seq_pkg::INT_STAT_OFS)
            int_stat_q <= (int_stat_q & ~prdata[laser_seq_pkg::EV_W-1:0]) | events;
        else
            int_stat_q <= int_stat_q | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(int_stat_q & int_mask_q);
    end
endmodule
`default_nettype wire

// ---- laser_seq_asserts.sv ----
// port-level assertion checker for the laser enable sequencer
`timescale 1ns/1ps
`default_nettype none
module laser_seq_asserts #(
    parameter int unsigned INHIBIT_CYCLES = laser_seq_pkg::INHIBIT_CYCLES
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       start_req,
    input wire logic       interlock_in,
    input wire logic       shutter_req,
    input wire logic       shutter_switch_open,
    input wire logic       keyswitch_on,
    input wire logic       unlatched_variant,
    input wire logic       pwm_cmd,
    input wire logic       rf_power_en,
    input wire logic       rf_drive,
    input wire logic       ready_out,
    input wire logic       shutter_open_out,
    input wire logic       interlock_open_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] rdy_q;
    logic [31:0] sht_q;
    // saturating counts of how long ready and shutter have stood
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) rdy_q <= 32'h0;
        else rdy_q <= !ready_out ? 32'h0 : rdy_q + 32'(rdy_q < INHIBIT_CYCLES);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sht_q <= 32'h0;
        else sht_q <= !shutter_open_out ? 32'h0 : sht_q + 32'(sht_q < INHIBIT_CYCLES);
    chk_start_hold: assert property (
        start_req ##1 start_req |=> !ready_out && !rf_drive) else $error("start held yet enabled");
    chk_ilock_rf: assert property (
        !interlock_in ##1 !interlock_in |=> !rf_power_en && !rf_drive) else $error("rf without ilock");
    chk_key_off: assert property (
        !unlatched_variant && !keyswitch_on ##1 !unlatched_variant && !keyswitch_on
        |=> !ready_out) else $error("ready with key off");
    chk_latch_hold: assert property (
        !unlatched_variant && !$fell(start_req) && !$rose(keyswitch_on)
        ##1 !unlatched_variant && !ready_out && !$fell(start_req) && !$rose(keyswitch_on)
        |=> !ready_out) else $error("ready rose without toggle");
    chk_unlatched_rdy: assert property (
        unlatched_variant && $past(unlatched_variant) && $past(presetn)
        |-> ready_out == $past(!start_req && interlock_in)) else $error("unlatched ready wrong");
    chk_shut_gate: assert property (
        !(shutter_req && shutter_switch_open) ##1 !(shutter_req && shutter_switch_open)
        |=> !rf_drive) else $error("rf drive with shutter shut");
    chk_ready_wait: assert property (
        rf_drive |-> rdy_q >= INHIBIT_CYCLES - 1) else $error("rf before ready countdown");
    chk_shut_wait: assert property (
        rf_drive |-> sht_q >= INHIBIT_CYCLES - 1) else $error("rf before shutter countdown");
    chk_rf_copy: assert property (
        rf_drive |-> $past(pwm_cmd) && ready_out && !interlock_open_out) else $error("bad rf");
    chk_apb_wait: assert property (
        psel && !penable |=> !pready ##1 pready) else $error("apb answer timing");
    chk_apb_err: assert property (
        pready |-> pslverr == (paddr > laser_seq_pkg::PWM_PERIOD_OFS || paddr[1:0] != 2'h0))
        else $error("apb error flag wrong");
endmodule
bind laser_enable_sequencer laser_seq_asserts #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .start_req, .interlock_in,
    .shutter_req, .shutter_switch_open, .keyswitch_on, .unlatched_variant, .pwm_cmd,
    .rf_power_en, .rf_drive, .ready_out, .shutter_open_out, .interlock_open_out);
`default_nettype wire

// ---- plc_model.sv ----
// external machine controller: start request pulses and pwm power command
`timescale 1ns/1ps
`default_nettype none
module plc_model #(
    parameter int unsigned SETTLE = 20
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] pwm_per,
    input  wire logic [15:0] pwm_high,
    input  wire logic        hold,
    input  wire logic        pulse,
    output logic             start_req,
    output logic             pwm_cmd
);
    logic [15:0] ph_q;
    logic [15:0] settle_q;
    logic [1:0]  pls_q;
    // period stays at or above 1000 cycles, i.e. at most 100 kHz
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) ph_q <= 16'h0;
        else ph_q <= (ph_q >= pwm_per - 16'h1 && ph_q >= 16'h03E7)
                     ? 16'h0 : ph_q + 16'h1;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) pwm_cmd <= 1'b0;
        else pwm_cmd <= ph_q < pwm_high;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) settle_q <= 16'h0;
        else settle_q <= settle_q + 16'(settle_q < SETTLE);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) pls_q <= 2'h0;
        else pls_q <= pulse ? 2'h3 : pls_q - 2'(pls_q != 2'h0);
    // supply settling: no request until the settle count has run
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) start_req <= 1'b0;
        else start_req <= settle_q == SETTLE && (hold || pls_q != 2'h0);
endmodule
`default_nettype wire

// ---- tb.sv ----
// testbench for the laser enable sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int IC = 20;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0, pulse = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] pwm_high = 16'h1F4;
    logic pready, pslverr, start_req, pwm_cmd, rf_power_en, rf_drive, ready_out;
    logic laser_active, shutter_open_out, interlock_open_out, irq;
    logic interlock_in = 1, shutter_req = 1, shutter_switch_open = 1;
    logic keyswitch_on = 0, unlatched_variant = 0;
    int errors = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    laser_enable_sequencer #(.INHIBIT_CYCLES(IC)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_req, .interlock_in,
        .shutter_req, .shutter_switch_open, .keyswitch_on, .unlatched_variant, .pwm_cmd,
        .rf_power_en, .rf_drive, .ready_out, .laser_active, .shutter_open_out,
        .interlock_open_out, .irq);
    plc_model u_plc (.pclk, .presetn, .pwm_per(16'h03E8), .pwm_high, .hold, .pulse,
        .start_req, .pwm_cmd);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        // an idle edge first, so a release and the next setup never share a time step
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        chk(pslverr, 32'(a > 8'h14 || a[1:0] != 2'h0));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r & m, exp);
    endtask
    // counts rf drive cycles over n clock cycles, one full pwm period when n is 1000
    task automatic rf_cnt(input int n, input logic [31:0] exp);
        logic [31:0] k;
        k = 32'h0;
        repeat (n)
        begin
            @(posedge pclk);
            k += 32'(rf_drive);
        end
        chk(k, exp);
    endtask
    task automatic arm;
        pulse <= 1'b1;
        @(posedge pclk);
        pulse <= 1'b0;
        cyc(8);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        cyc(40000);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        cyc(20);
        presetn <= 1'b1;
        rd(8'h00, 32'hFFFFFFFF, 32'h1);
        rd(8'h0C, 32'hFFFFFFFF, 32'h0);
        rd(8'h18, 32'hFFFFFFFF, 32'h0);
        apb(1'b1, 8'h0C, 32'hF);
        rd(8'h0C, 32'hFFFFFFFF, 32'hF);
        $display("registers done");
        arm();
        chk(ready_out, 0);
        hold <= 1'b1;
        cyc(4);
        keyswitch_on <= 1'b1;
        cyc(6);
        chk({ready_out, rf_power_en}, 0);
        hold <= 1'b0;
        cyc(4);
        chk({ready_out, rf_drive}, 2'b10);
        cyc(3 * IC);
        for (int i = 0; i < 2; i++)
        begin
            pwm_high <= (i != 0) ? 16'h3B6 : 16'h1F4;
            cyc(1000);
            rf_cnt(1000, (i != 0) ? 32'h3B6 : 32'h1F4);
        end
        rd(8'h10, 32'hFFFF, 32'h3B6);
        rd(8'h14, 32'hFFFF, 32'h3E8);
        rd(8'h04, 32'h1FF, 32'hFF);
        chk(laser_active, 32'h1);
        chk(irq, 1);
        rd(8'h08, 32'h9, 32'h9);
        rd(8'h08, 32'hF, 32'h0);
        cyc(2);
        chk(irq, 0);
        $display("arming done");
        shutter_req <= 1'b0;
        cyc(1);
        rf_cnt(1000, 32'h0);
        chk(shutter_open_out, 32'h0);
        shutter_req <= 1'b1;
        rf_cnt(IC + 2, 32'h0);
        cyc(2 * IC);
        shutter_switch_open <= 1'b0;
        cyc(1);
        rf_cnt(1000, 32'h0);
        shutter_switch_open <= 1'b1;
        cyc(3 * IC);
        apb(1'b1, 8'h00, 32'h0);
        cyc(1);
        rf_cnt(1000, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        $display("shutter done");
        interlock_in <= 1'b0;
        cyc(4);
        chk({interlock_open_out, rf_power_en}, 2'b10);
        interlock_in <= 1'b1;
        cyc(3 * IC);
        chk(ready_out, 0);
        rd(8'h08, 32'h4, 32'h4);
        arm();
        chk(ready_out, 1);
        $display("latch done");
        unlatched_variant <= 1'b1;
        keyswitch_on <= 1'b0;
        interlock_in <= 1'b0;
        cyc(4);
        interlock_in <= 1'b1;
        cyc(4);
        chk(ready_out, 1);
        cyc(3 * IC);
        rf_cnt(1000, 950);
        $display("unlatched done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
